// ==== core/cbt_top.sv ====
// CAN bit timing configuration register, quantum and segment sequencer
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cbt_cfg.svh"

module cbt_top
(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire logic [31:0]        hwdata,
  output var  logic [31:0]        hrdata,
  output var  logic               hreadyout,
  output var  logic               hresp,
  // CAN receive line, synchronous to hclk
  input  wire logic               can_rx,
  // Timing strobes and settings
  output var  cbt_pkg::cbt_timing_s timing_out
);

  cbt_pkg::cbt_state_s st_ff;
  cbt_pkg::cbt_state_s nxt_st;

  // Larger of two three-bit codes
  function automatic logic [2:0] max3(input logic [2:0] a,
                                      input logic [2:0] b);
    max3 = (a > b) ? a : b;
  endfunction : max3

  // Phase two code in use for a given timing word
  function automatic logic [2:0] ph2_code(input logic [31:0] t);
    logic [2:0] p1;
    logic [2:0] p2;
    p1 = t[`CBT_PH1_HI:`CBT_PH1_LO];
    p2 = t[`CBT_PH2_HI:`CBT_PH2_LO];
    if (t[`CBT_PH2SEL_BIT])
      ph2_code = (p2 > p1) ? p1 : p2;
    else
      ph2_code = max3(p1, `CBT_IPT_CODE);
  endfunction : ph2_code

  // Majority of three samples
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : vote3

  logic        addr_ok;
  logic        in_cfg;
  logic [2:0]  prop_c;
  logic [2:0]  ph1_c;
  logic [2:0]  ph2_c;
  logic [5:0]  pre_c;
  logic [6:0]  presc_top;
  logic [4:0]  qpb;
  logic        tick;
  logic [2:0]  seg_last;
  logic [31:0] wr_t;

  // Field views of the stored timing word
  always_comb
  begin
    prop_c    = st_ff.timing[`CBT_PROP_HI:`CBT_PROP_LO];
    ph1_c     = st_ff.timing[`CBT_PH1_HI:`CBT_PH1_LO];
    ph2_c     = ph2_code(st_ff.timing);
    pre_c     = st_ff.timing[`CBT_PRE_HI:`CBT_PRE_LO];
    // Quantum is 2*(prescaler+1) clocks, so counter wraps at 2p+1
    presc_top = {pre_c, 1'b1};
    in_cfg    = (st_ff.operating_mode_field == `CBT_MODE_CONFIG);
    tick      = !in_cfg && (st_ff.presc_cnt == presc_top);
    // Sync quantum plus each segment code plus one
    qpb       = 5'd4 + 5'(prop_c) + 5'(ph1_c) + 5'(ph2_c);
    addr_ok   = hsel && hready && htrans[1];
  end

  // Last quantum code of the current segment
  always_comb
  begin
    case (st_ff.seg)
      cbt_pkg::seg_sync: seg_last = 3'h0;
      cbt_pkg::seg_prop: seg_last = prop_c;
      cbt_pkg::seg_ph1:  seg_last = ph1_c;
      cbt_pkg::seg_ph2:  seg_last = ph2_c;
      default:           seg_last = 3'h0;
    endcase
  end

  // Incoming timing word with the derived phase two folded in
  always_comb
  begin
    wr_t = hwdata & `CBT_TIMING_MASK;
    if (!wr_t[`CBT_PH2SEL_BIT])
      wr_t[`CBT_PH2_HI:`CBT_PH2_LO] = ph2_code(wr_t);
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tim.tq_tick    = 1'b0;
    nxt_st.tim.bit_start  = 1'b0;
    nxt_st.tim.sample_pls = 1'b0;

    // Address phase capture; read data prepared for the data phase
    nxt_st.dp_sel = addr_ok;
    nxt_st.dp_wr  = addr_ok && hwrite;
    nxt_st.dp_addr = haddr[3:0];
    nxt_st.hrdata = 32'h0000_0000;
    if (addr_ok && !hwrite)
    begin
      case (haddr[3:0])
        `CBT_OFS_CTRL:
          nxt_st.hrdata[`CBT_MODE_HI:`CBT_MODE_LO] =
            st_ff.operating_mode_field;
        `CBT_OFS_TIMING:
          nxt_st.hrdata = st_ff.timing;
        `CBT_OFS_STATUS:
        begin
          nxt_st.hrdata[`CBT_STAT_QPB_LO +: 5] = qpb;
          nxt_st.hrdata[`CBT_STAT_SEG_LO +: 2] = st_ff.seg;
          nxt_st.hrdata[`CBT_STAT_BIT]         = st_ff.tim.bit_val;
          nxt_st.hrdata[`CBT_STAT_RUN]         = !in_cfg;
        end
        default:
          nxt_st.hrdata = 32'h0000_0000;
      endcase
    end

    // Data phase write; mode write does not gate itself
    if (st_ff.dp_wr)
    begin
      case (st_ff.dp_addr)
        `CBT_OFS_CTRL:
          nxt_st.operating_mode_field =
            hwdata[`CBT_MODE_HI:`CBT_MODE_LO];
        `CBT_OFS_TIMING:
          if (in_cfg)
            nxt_st.timing = wr_t;
        default:
          nxt_st.timing = st_ff.timing;
      endcase
    end

    // Prescaler: one quantum tick per 2*(prescaler+1) clocks
    if (in_cfg || tick)
      nxt_st.presc_cnt = 7'h00;
    else
      nxt_st.presc_cnt = st_ff.presc_cnt + 7'h01;

    // Sequencer is parked at sync while being configured
    if (in_cfg)
    begin
      nxt_st.seg    = cbt_pkg::seg_sync;
      nxt_st.tq_cnt = 3'h0;
    end
    else if (tick)
    begin
      nxt_st.tim.tq_tick = 1'b1;
      // Line sampled once per quantum for the vote history
      nxt_st.samp = {st_ff.samp[1:0], can_rx};
      if (st_ff.tq_cnt == seg_last)
      begin
        nxt_st.tq_cnt = 3'h0;
        case (st_ff.seg)
          cbt_pkg::seg_sync: nxt_st.seg = cbt_pkg::seg_prop;
          cbt_pkg::seg_prop: nxt_st.seg = cbt_pkg::seg_ph1;
          cbt_pkg::seg_ph1:
          begin
            nxt_st.seg = cbt_pkg::seg_ph2;
            nxt_st.tim.sample_pls = 1'b1;
            // Vote uses the two previous quanta and this one
            if (st_ff.timing[`CBT_TRIPLE_BIT])
              nxt_st.tim.bit_val = vote3({st_ff.samp[1:0], can_rx});
            else
              nxt_st.tim.bit_val = can_rx;
          end
          cbt_pkg::seg_ph2:
          begin
            nxt_st.seg = cbt_pkg::seg_sync;
            nxt_st.tim.bit_start = 1'b1;
          end
          default: nxt_st.seg = cbt_pkg::seg_sync;
        endcase
      end
      else
        nxt_st.tq_cnt = st_ff.tq_cnt + 3'h1;
    end

    // Wake path: filtered needs a stable change, else straight through
    if (st_ff.timing[`CBT_WAKE_BIT])
    begin
      if (can_rx == st_ff.tim.wake_rx)
        nxt_st.filt_cnt = 3'h0;
      else if (st_ff.filt_cnt == `CBT_FILT_CYC - 3'h1)
      begin
        nxt_st.filt_cnt    = 3'h0;
        nxt_st.tim.wake_rx = can_rx;
      end
      else
        nxt_st.filt_cnt = st_ff.filt_cnt + 3'h1;
    end
    else
    begin
      nxt_st.filt_cnt    = 3'h0;
      nxt_st.tim.wake_rx = can_rx;
    end

    nxt_st.tim.triple_vote_enable = st_ff.timing[`CBT_TRIPLE_BIT];
    nxt_st.tim.resync_jump_width =
      st_ff.timing[`CBT_SJW_HI:`CBT_SJW_LO];
  end

  // State register; idle line is recessive high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff                      <= '0;
      st_ff.operating_mode_field <= `CBT_MODE_RST;
      st_ff.timing               <= `CBT_TIMING_RST;
      st_ff.seg                  <= cbt_pkg::seg_sync;
      st_ff.samp                 <= 3'h7;
      st_ff.tim.bit_val          <= 1'b1;
      st_ff.tim.wake_rx          <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // Zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = st_ff.hrdata;
  assign timing_out = st_ff.tim;

endmodule : cbt_top
`default_nettype wire

// ==== core/cbt_cfg.svh ====
// Address map, field layout and timing figures of the bit timing block
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH
`define CBT_OFS_CTRL     4'h0
`define CBT_OFS_TIMING   4'h4
`define CBT_OFS_STATUS   4'h8
`define CBT_MODE_HI      23
`define CBT_MODE_LO      21
`define CBT_MODE_CONFIG  3'h4
`define CBT_MODE_RST     3'h4
`define CBT_WAKE_BIT     22
`define CBT_PH2_HI       18
`define CBT_PH2_LO       16
`define CBT_PH2SEL_BIT   15
`define CBT_TRIPLE_BIT   14
`define CBT_PH1_HI       13
`define CBT_PH1_LO       11
`define CBT_PROP_HI      10
`define CBT_PROP_LO      8
`define CBT_SJW_HI       7
`define CBT_SJW_LO       6
`define CBT_PRE_HI       5
`define CBT_PRE_LO       0
`define CBT_TIMING_MASK  32'h0047_ffff
`define CBT_TIMING_RST   32'h0000_0000
`define CBT_IPT_CODE     3'h1
`define CBT_FILT_NS      160
`define CBT_CLK_NS       40
`define CBT_FILT_CYC     3'((`CBT_FILT_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_STAT_QPB_LO  0
`define CBT_STAT_SEG_LO  8
`define CBT_STAT_BIT     12
`define CBT_STAT_RUN     13
`endif

// ==== core/cbt_pkg.sv ====
// Types shared by the bit timing block
package cbt_pkg;
  typedef enum logic [1:0] {
    seg_sync,
    seg_prop,
    seg_ph1,
    seg_ph2
  } cbt_seg_e;

  // Timing strobes and settings seen by the bit stream logic
  typedef struct packed {
    logic       tq_tick;
    logic       bit_start;
    logic       sample_pls;
    logic       bit_val;
    logic       triple_vote_enable;
    logic [1:0] resync_jump_width;
    logic       wake_rx;
  } cbt_timing_s;

  typedef struct packed {
    logic [2:0]  operating_mode_field;
    logic [31:0] timing;
    logic        dp_wr;
    logic        dp_sel;
    logic [3:0]  dp_addr;
    logic [6:0]  presc_cnt;
    logic [2:0]  tq_cnt;
    cbt_seg_e    seg;
    logic [2:0]  samp;
    logic [2:0]  filt_cnt;
    logic [31:0] hrdata;
    cbt_timing_s tim;
  } cbt_state_s;
endpackage : cbt_pkg

// ==== verif/cbt_top_properties.sv ====
// Port checks for the bit timing block
`timescale 1ns/10ps
`default_nettype none
module cbt_top_properties
(
  // Clock, reset, bus answer
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  // Line and strobes
  input wire logic                 can_rx,
  input wire cbt_pkg::cbt_timing_s timing_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_zero_wait: assert property (hreadyout) else $error("wait state");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_tick_single:
    assert property (timing_out.tq_tick |=> !timing_out.tq_tick)
    else $error("short quantum");
  a_sample_tick:
    assert property (timing_out.sample_pls |-> timing_out.tq_tick)
    else $error("sample off tick");
  a_end_tick:
    assert property (timing_out.bit_start |->
      timing_out.tq_tick && !timing_out.sample_pls) else $error("bad end");
  a_bit_length:
    assert property (timing_out.bit_start |=> !timing_out.bit_start [*7])
    else $error("short bit");
  a_value_hold:
    assert property ($changed(timing_out.bit_val) |->
      timing_out.sample_pls || $past(timing_out.sample_pls))
    else $error("value moved");
  a_wake_level:
    assert property ($changed(timing_out.wake_rx) |->
      timing_out.wake_rx == $past(can_rx)) else $error("wake level");
endmodule : cbt_top_properties
// Every instance of the block gets the checks
bind cbt_top cbt_top_properties u_cbt_top_properties (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .can_rx(can_rx), .timing_out(timing_out));
`default_nettype wire

// ==== verif/cbt_remote_node.sv ====
// Remote node driving the receive line
`timescale 1ns/10ps
`default_nettype none
module cbt_remote_node
(
  // Clock, reset, bit boundary
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic bit_start,
  // Forced disturbance and line
  input  wire logic glitch,
  output var  logic can_rx
);
  logic [7:0] lfsr_ff;
  // New level only at a bit boundary; recessive after reset
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lfsr_ff <= 8'h5b;
    else if (bit_start)
      lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
  // Glitch flips the line without moving the bit pattern
  assign can_rx = lfsr_ff[0] ^ glitch;
endmodule : cbt_remote_node
`default_nettype wire

// ==== verif/cbt_top_test.sv ====
// Self-checking bench for the bit timing block
`timescale 1ns/10ps
`default_nettype none
module cbt_top_test;
  cbt_pkg::cbt_timing_s tmo;
  logic        hclk, hresetn, hsel, hwrite, glitch, rd_ff, rdy, hresp;
  logic        can_rx;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] exp_q[$];
  int          err_count, total_checks;
  cbt_top u_cbt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(rdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(hresp), .can_rx(can_rx), .timing_out(tmo));
  cbt_remote_node u_cbt_remote_node (.hclk(hclk), .hresetn(hresetn),
    .bit_start(tmo.bit_start), .glitch(glitch), .can_rx(can_rx));
  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Read data phase: oldest note against the bus
  always @(posedge hclk)
    rd_ff <= hsel & htrans[1] & !hwrite;
  always @(negedge hclk)
    if (rd_ff === 1'b1)
      chk("hrdata", exp_q.pop_front(), hrdata);
  // One transfer; for a read d is the expected word
  task automatic bus(input logic w, logic [3:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {28'h0, a};
    do @(posedge hclk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
      exp_q.push_back(d);
    do @(posedge hclk); while (rdy !== 1'b1);
  endtask : bus
  // Bounded wait for strobe bit s; n counts the falling edges
  task automatic gap(input int s, output int n);
    @(negedge hclk);
    for (n = 1; n < 4000 && tmo[s] !== 1'b1; n++)
      @(negedge hclk);
  endtask : gap
  // Random legal setting: program, glitch, run, refuse, measure
  task automatic cfg();
    logic [2:0]  p1, p2, pr, pe;
    logic [5:0]  ps;
    logic [1:0]  sj;
    logic        sel, tv, wk, b;
    logic [31:0] w, e;
    int          n, k, q;
    {p1, p2, pr, sel, wk} = 11'($urandom);
    ps = 6'($urandom % 4);
    tv = ps[1] & 1'($urandom);
    if (sel && p2 > p1)
      p2 = p1;
    pe = sel ? p2 : (p1 > 1) ? p1 : 3'h1;
    if (4 + pr + p1 + pe < 8)
      pr = 3'h7;
    sj = (pe > 2) ? 2'h3 : pe[1:0];
    q = 2 * (ps + 1);
    w = {9'h0, wk, 3'h0, p2, sel, tv, p1, pr, sj, ps};
    e = w;
    e[18:16] = pe;
    bus(1, 4'h0, 32'h0080_0000);
    bus(1, 4'h4, w | ($urandom & 32'hffb8_0000));
    bus(0, 4'h4, e);
    b = can_rx;
    k = 0;
    for (n = 0; n < 10; n++)
    begin
      @(posedge hclk);
      glitch <= (n < 2);
      @(negedge hclk);
      k += (tmo.wake_rx !== b);
    end
    chk("wake", wk ? 0 : 2, k);
    bus(1, 4'h0, 32'h0);
    bus(1, 4'h4, ~w);
    bus(0, 4'h4, e);
    gap(6, n);
    gap(5, n);
    chk("sample", (3 + pr + p1) * q, n);
    @(negedge hclk);
    chk("bit", {31'h0, can_rx}, {31'h0, tmo.bit_val});
    chk("vote", {tv, sj}, tmo[3:1]);
    gap(6, n);
    chk("end", (pe + 1) * q - 1, n);
  endtask : cfg
  // Hang guard
  initial
  begin
    #2_000_000;
    err_count++;
    report_and_stop();
  end
  // Reset, reset values, unmapped place, random settings
  initial
  begin
    {hresetn, hsel, hwrite, glitch} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'h36b01a52));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 4'h0, 32'h0080_0000);
    bus(0, 4'h4, 32'h0);
    // Status after reset: 5 quanta, parked at sync, idle bit, stopped
    bus(0, 4'h8, 32'h0000_1005);
    bus(1, 4'h8, 32'hffff_ffff);
    bus(0, 4'h8, 32'h0000_1005);
    bus(1, 4'hc, 32'hffff_ffff);
    bus(0, 4'hc, 32'h0);
    repeat (8) cfg();
    report_and_stop();
  end
endmodule : cbt_top_test
`default_nettype wire
